/* File: logic/dma_chan_pkg.sv */
/*
 * Constants for one DMA channel register block: APB offsets, control and
 * status field positions, reset values and pointer step encodings.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
package dma_chan_pkg;
	localparam int          ADDR_W             = 8;
	localparam logic [7:0]  OFS_A_CURRENT      = 8'h00;
	localparam logic [7:0]  OFS_A_START        = 8'h04;
	localparam logic [7:0]  OFS_B_CURRENT      = 8'h08;
	localparam logic [7:0]  OFS_B_START        = 8'h0C;
	localparam logic [7:0]  OFS_COUNT_REMAIN   = 8'h10;
	localparam logic [7:0]  OFS_COUNT_RELOAD   = 8'h14;
	localparam logic [7:0]  OFS_CONTROL        = 8'h1C;
	localparam logic [7:0]  OFS_STATUS         = 8'h20;

	localparam int          PTR_W              = 24;
	localparam int          CNT_W              = 16;
	localparam logic [15:0] COUNT_MAX          = 16'hFFFF;
	localparam logic [15:0] CONTROL_RESET      = 16'h0000;
	localparam logic [23:0] PTR_RESET          = 24'h000000;
	localparam logic [15:0] COUNT_RESET        = 16'h0000;

	// Control word fields
	localparam int          CTL_CHANNEL_ON     = 0;
	localparam int          CTL_DONE_IRQ_EN    = 1;
	localparam int          CTL_OVR_IRQ_EN     = 2;
	localparam int          CTL_WORD_SIZE      = 3;
	localparam int          CTL_MEM_TO_MEM     = 4;
	localparam int          CTL_DIRECTION      = 5;
	localparam int          CTL_RELOAD_MODE    = 6;
	localparam int          CTL_BURST_POLICY   = 7;
	localparam int          CTL_SOFT_REQUEST   = 8;
	localparam int          CTL_A_STEP_EN      = 9;
	localparam int          CTL_A_STEP_LO      = 10;
	localparam int          CTL_B_STEP_EN      = 12;
	localparam int          CTL_B_STEP_LO      = 13;
	localparam logic [15:0] CONTROL_WMASK      = 16'h7FFF;

	// Status fields
	localparam int          ST_TERMINAL        = 0;
	localparam int          ST_OVERRUN         = 1;
	localparam int          ST_BUSY            = 2;
	localparam int          ST_VALID           = 3;

	// Pointer step encodings
	localparam logic [1:0]  STEP_INC1          = 2'h0;
	localparam logic [1:0]  STEP_INC2          = 2'h1;
	localparam logic [1:0]  STEP_DEC1          = 2'h2;
	localparam logic [1:0]  STEP_DEC2          = 2'h3;
endpackage

/* File: logic/dma_channel_control_status.sv */
/*
 * One DMA channel: APB register file, block counter, pointer stepping,
 * buffered and auto-initialize continuation, sticky status and interrupt.
 * Assumes the bus engine pulses XFER_DONE once per finished transfer cycle.
 */
`timescale 1ns/10ps
module dma_channel_control_status (
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        HW_TRANSFER_REQUEST,
	input  wire logic        XFER_DONE,
	output logic             XFER_REQ,
	output logic             HOLD_BUS,
	output logic             DIR_A_DEST,
	output logic             WORD_SIZE,
	output logic             MEM_TO_MEM,
	output logic      [23:0] A_ADDR,
	output logic      [23:0] B_ADDR,
	output logic             DMA_CLK_EN,
	output logic             IRQ
);
	logic [23:0] a_current_reg;
	logic [23:0] a_start_reg;
	logic [23:0] b_current_reg;
	logic [23:0] b_start_reg;
	logic [15:0] count_remaining_reg;
	logic [15:0] count_reload_reg;
	logic [15:0] control_reg;
	logic        terminal_reg;
	logic        overrun_reg;
	logic        valid_reg;

	logic        wr_en;
	logic        rd_en;
	logic        addr_hit;
	logic        busy;
	logic        request;
	logic        block_end;
	logic        reload_now;
	logic        auto_mode;
	logic        memory_mode;
	logic [15:0] count_wr_value;
	logic [15:0] reload_value;

	function automatic logic [23:0] step_ptr(input logic [23:0] p, input logic [1:0] s);
		case (s)
			dma_chan_pkg::STEP_INC1: step_ptr = p + 24'h000001;
			dma_chan_pkg::STEP_INC2: step_ptr = p + 24'h000002;
			dma_chan_pkg::STEP_DEC1: step_ptr = p - 24'h000001;
			default:                 step_ptr = p - 24'h000002;
		endcase
	endfunction

	// Every access completes in its first access cycle
	assign PREADY = 1'b1;
	assign wr_en  = PSEL & PENABLE & PWRITE;
	assign rd_en  = PSEL & PENABLE & ~PWRITE;

	always_comb begin
		case (PADDR)
			dma_chan_pkg::OFS_A_CURRENT,
			dma_chan_pkg::OFS_A_START,
			dma_chan_pkg::OFS_B_CURRENT,
			dma_chan_pkg::OFS_B_START,
			dma_chan_pkg::OFS_COUNT_REMAIN,
			dma_chan_pkg::OFS_COUNT_RELOAD,
			dma_chan_pkg::OFS_CONTROL,
			dma_chan_pkg::OFS_STATUS: addr_hit = 1'b1;
			default:                  addr_hit = 1'b0;
		endcase
	end

	assign PSLVERR = PSEL & PENABLE & ~addr_hit;

	assign auto_mode   = control_reg[dma_chan_pkg::CTL_RELOAD_MODE];
	assign memory_mode = control_reg[dma_chan_pkg::CTL_MEM_TO_MEM];
	assign busy        = control_reg[dma_chan_pkg::CTL_CHANNEL_ON] & (count_remaining_reg != 16'h0000);
	assign request     = HW_TRANSFER_REQUEST | control_reg[dma_chan_pkg::CTL_SOFT_REQUEST];

	// Nothing moves while disabled; the count reaching zero ends the block
	assign XFER_REQ  = busy & request;
	assign HOLD_BUS  = busy & request & control_reg[dma_chan_pkg::CTL_BURST_POLICY];
	assign block_end = busy & XFER_DONE & (count_remaining_reg == 16'h0001);
	assign reload_now = block_end & (auto_mode | valid_reg);

	// Zero written as a count stands for the longest block
	assign count_wr_value = (PWDATA[15:0] == 16'h0000) ? dma_chan_pkg::COUNT_MAX : PWDATA[15:0];
	assign reload_value   = (count_reload_reg == 16'h0000) ? dma_chan_pkg::COUNT_MAX : count_reload_reg;

	assign DIR_A_DEST = control_reg[dma_chan_pkg::CTL_DIRECTION];
	assign WORD_SIZE  = control_reg[dma_chan_pkg::CTL_WORD_SIZE];
	assign MEM_TO_MEM = memory_mode;
	assign A_ADDR     = a_current_reg;
	// Flyby shows no Device B address so nothing downstream latches a stale one
	assign B_ADDR     = memory_mode ? b_current_reg : dma_chan_pkg::PTR_RESET;
	// Single channel here: its enable alone keeps the DMA clock running
	assign DMA_CLK_EN = control_reg[dma_chan_pkg::CTL_CHANNEL_ON];
	assign IRQ = (terminal_reg & control_reg[dma_chan_pkg::CTL_DONE_IRQ_EN])
	           | (overrun_reg & control_reg[dma_chan_pkg::CTL_OVR_IRQ_EN]);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			control_reg <= dma_chan_pkg::CONTROL_RESET;
		end else if (wr_en && PADDR == dma_chan_pkg::OFS_CONTROL) begin
			control_reg <= PWDATA[15:0] & dma_chan_pkg::CONTROL_WMASK;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			a_start_reg      <= dma_chan_pkg::PTR_RESET;
			b_start_reg      <= dma_chan_pkg::PTR_RESET;
			count_reload_reg <= dma_chan_pkg::COUNT_RESET;
		end else if (wr_en) begin
			if (PADDR == dma_chan_pkg::OFS_A_START) begin
				a_start_reg <= PWDATA[23:0];
			end
			if (PADDR == dma_chan_pkg::OFS_B_START) begin
				b_start_reg <= PWDATA[23:0];
			end
			if (PADDR == dma_chan_pkg::OFS_COUNT_RELOAD) begin
				count_reload_reg <= PWDATA[15:0];
			end
		end
	end

	// Device A pointer: software write, block reload, then per-transfer step
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			a_current_reg <= dma_chan_pkg::PTR_RESET;
		end else if (wr_en && PADDR == dma_chan_pkg::OFS_A_CURRENT) begin
			a_current_reg <= PWDATA[23:0];
		end else if (reload_now) begin
			a_current_reg <= a_start_reg;
		end else if (busy && XFER_DONE && control_reg[dma_chan_pkg::CTL_A_STEP_EN]) begin
			a_current_reg <= step_ptr(a_current_reg,
				control_reg[dma_chan_pkg::CTL_A_STEP_LO +: 2]);
		end
	end

	// Device B pointer: software write in any mode, reload and step only in memory-to-memory transfers
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			b_current_reg <= dma_chan_pkg::PTR_RESET;
		end else if (wr_en && PADDR == dma_chan_pkg::OFS_B_CURRENT) begin
			b_current_reg <= PWDATA[23:0];
		end else if (reload_now && memory_mode) begin
			b_current_reg <= b_start_reg;
		end else if (busy && XFER_DONE && memory_mode && control_reg[dma_chan_pkg::CTL_B_STEP_EN]) begin
			b_current_reg <= step_ptr(b_current_reg,
				control_reg[dma_chan_pkg::CTL_B_STEP_LO +: 2]);
		end
	end

	// Writing enable 1 restarts a stopped channel from its pending reload count; pointers keep their values
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			count_remaining_reg <= dma_chan_pkg::COUNT_RESET;
		end else if (wr_en && PADDR == dma_chan_pkg::OFS_COUNT_REMAIN) begin
			count_remaining_reg <= count_wr_value;
		end else if (reload_now) begin
			count_remaining_reg <= reload_value;
		end else if (wr_en && PADDR == dma_chan_pkg::OFS_CONTROL
		             && PWDATA[dma_chan_pkg::CTL_CHANNEL_ON]
		             && count_remaining_reg == 16'h0000 && valid_reg) begin
			count_remaining_reg <= reload_value;
		end else if (busy && XFER_DONE) begin
			// Reaching zero here stops a buffered block with nothing pending
			count_remaining_reg <= count_remaining_reg - 16'h0001;
		end
	end

	// Sticky flags: a hardware set in the clear cycle wins over the clear
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			terminal_reg <= 1'b0;
			overrun_reg  <= 1'b0;
		end else begin
			if (block_end) begin
				terminal_reg <= 1'b1;
			end else if (wr_en && PADDR == dma_chan_pkg::OFS_STATUS && PWDATA[dma_chan_pkg::ST_TERMINAL]) begin
				terminal_reg <= 1'b0;
			end
			if (block_end && (auto_mode ? terminal_reg : ~valid_reg)) begin
				overrun_reg <= 1'b1;
			end else if (wr_en && PADDR == dma_chan_pkg::OFS_STATUS && PWDATA[dma_chan_pkg::ST_OVERRUN]) begin
				overrun_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			valid_reg <= 1'b0;
		end else if (wr_en && PADDR == dma_chan_pkg::OFS_COUNT_RELOAD) begin
			valid_reg <= 1'b1;
		end else if ((reload_now && !auto_mode)
		             || (wr_en && PADDR == dma_chan_pkg::OFS_CONTROL
		                 && PWDATA[dma_chan_pkg::CTL_CHANNEL_ON]
		                 && count_remaining_reg == 16'h0000 && valid_reg)) begin
			valid_reg <= 1'b0;
		end else if (wr_en && PADDR == dma_chan_pkg::OFS_STATUS && PWDATA[dma_chan_pkg::ST_VALID]) begin
			valid_reg <= 1'b0;
		end
	end

	// Read data is registered; reserved bits read zero
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PRDATA <= 32'h00000000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			case (PADDR)
				dma_chan_pkg::OFS_A_CURRENT:    PRDATA <= {8'h00, a_current_reg};
				dma_chan_pkg::OFS_A_START:      PRDATA <= {8'h00, a_start_reg};
				dma_chan_pkg::OFS_B_CURRENT:    PRDATA <= {8'h00, b_current_reg};
				dma_chan_pkg::OFS_B_START:      PRDATA <= {8'h00, b_start_reg};
				dma_chan_pkg::OFS_COUNT_REMAIN: PRDATA <= {16'h0000, count_remaining_reg};
				dma_chan_pkg::OFS_COUNT_RELOAD: PRDATA <= {16'h0000, count_reload_reg};
				dma_chan_pkg::OFS_CONTROL:      PRDATA <= {16'h0000, control_reg};
				dma_chan_pkg::OFS_STATUS:       PRDATA <= {28'h0000000, valid_reg, busy,
				                                          overrun_reg, terminal_reg};
				default:                        PRDATA <= 32'h00000000;
			endcase
		end
	end
endmodule // dma_channel_control_status

/* File: tb/dma_channel_control_status_checker.sv */
/* Port relations of one DMA channel register block.
   Assumes it is bound to dma_channel_control_status, one clock, async reset. */
`timescale 1ns/10ps
module dma_channel_control_status_checker (
	input wire logic        SYS_CLK, RST_N, PSEL, PENABLE, PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA, PRDATA,
	input wire logic        XFER_DONE, XFER_REQ, HOLD_BUS, DMA_CLK_EN,
	input wire logic        DIR_A_DEST, WORD_SIZE, MEM_TO_MEM,
	input wire logic [23:0] A_ADDR, B_ADDR
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	wire wr = PSEL && PENABLE && PWRITE;
	wire ctl = wr && PADDR == dma_chan_pkg::OFS_CONTROL;
	wire rd_b = PSEL && PENABLE && !PWRITE && PADDR == dma_chan_pkg::OFS_B_START;
	property p_bstart; rd_b |-> PRDATA[31:24] == 8'h00; endproperty
	a_bstart: assert property (p_bstart) else $error("B start upper bits set");
	property p_flyby; !MEM_TO_MEM |-> B_ADDR == 24'h000000; endproperty
	a_flyby: assert property (p_flyby) else $error("B pointer used in flyby");
	property p_on; XFER_REQ |-> DMA_CLK_EN; endproperty
	a_on: assert property (p_on) else $error("Request while disabled");
	property p_hold; HOLD_BUS |-> XFER_REQ; endproperty
	a_hold: assert property (p_hold) else $error("Bus held without request");
	property p_gate; ctl |=> DMA_CLK_EN == $past(PWDATA[0]); endproperty
	a_gate: assert property (p_gate) else $error("Clock enable wrong");
	property p_mode; ctl |=> {DIR_A_DEST, MEM_TO_MEM, WORD_SIZE} == $past(PWDATA[5:3]); endproperty
	a_mode: assert property (p_mode) else $error("Mode outputs wrong");
	// A pointer moves only on a finished transfer or a register write
	property p_astill; !XFER_DONE && !wr |=> $stable(A_ADDR); endproperty
	a_astill: assert property (p_astill) else $error("A pointer moved");
	property p_idle; XFER_DONE && !DMA_CLK_EN && !wr |=> $stable(A_ADDR); endproperty
	a_idle: assert property (p_idle) else $error("Transfer while disabled");
	c_hold: cover property (HOLD_BUS);
	c_m2m: cover property (XFER_DONE && MEM_TO_MEM);
	c_fly: cover property (XFER_DONE && !MEM_TO_MEM);
endmodule // dma_channel_control_status_checker

bind dma_channel_control_status dma_channel_control_status_checker u_chk (
	.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .XFER_DONE(XFER_DONE), .XFER_REQ(XFER_REQ),
	.HOLD_BUS(HOLD_BUS), .DMA_CLK_EN(DMA_CLK_EN), .DIR_A_DEST(DIR_A_DEST), .WORD_SIZE(WORD_SIZE),
	.MEM_TO_MEM(MEM_TO_MEM), .A_ADDR(A_ADDR), .B_ADDR(B_ADDR)
);

/* File: tb/dma_channel_control_status_tb_top.sv */
/* Bench: APB master, reference pointer arithmetic and block scenarios.
   Assumes package, design, checker and engine model compile first. */
`timescale 1ns/10ps
module dma_channel_control_status_tb_top;
	logic        SYS_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic        HW_TRANSFER_REQUEST = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h00000000, PRDATA, rdata;
	logic [23:0] A_ADDR, B_ADDR;
	logic [3:0]  gap = 4'h0;
	logic        rerr;
	logic        PREADY, PSLVERR, XFER_DONE, XFER_REQ, HOLD_BUS, DIR_A_DEST, WORD_SIZE, MEM_TO_MEM, DMA_CLK_EN, IRQ;
	int          num_errors = 0, n_tests = 0;
	int          stp [4] = '{1, 2, -1, -2};
	always #5 SYS_CLK = ~SYS_CLK;
	dma_channel_control_status dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.HW_TRANSFER_REQUEST(HW_TRANSFER_REQUEST), .XFER_DONE(XFER_DONE), .XFER_REQ(XFER_REQ),
		.HOLD_BUS(HOLD_BUS), .DIR_A_DEST(DIR_A_DEST), .WORD_SIZE(WORD_SIZE), .MEM_TO_MEM(MEM_TO_MEM),
		.A_ADDR(A_ADDR), .B_ADDR(B_ADDR), .DMA_CLK_EN(DMA_CLK_EN), .IRQ(IRQ));
	xfer_engine_model engine (.clk(SYS_CLK), .rst_n(RST_N), .xfer_req(XFER_REQ), .hold_bus(HOLD_BUS),
		.gap(gap), .xfer_done(XFER_DONE));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		@(posedge SYS_CLK);
		while (PREADY !== 1'b1) @(posedge SYS_CLK);
		rdata = PRDATA;
		rerr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(rdata, exp);
	endtask
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#300000;
		num_errors++;
		conclude();
	end
	initial begin
		logic [23:0] a0, b0, as, bs;
		logic [15:0] ctl;
		int n, rl;
		void'($urandom(5));
		repeat (12) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		rd(dma_chan_pkg::OFS_STATUS, 32'h00000000);
		bus(1'b1, dma_chan_pkg::OFS_B_START, 32'hFFFFFFFF);
		rd(dma_chan_pkg::OFS_B_START, 32'h00FFFFFF);
		bus(1'b1, dma_chan_pkg::OFS_COUNT_REMAIN, 32'h00000000);
		rd(dma_chan_pkg::OFS_COUNT_REMAIN, 32'h0000FFFF);
		bus(1'b1, dma_chan_pkg::OFS_COUNT_RELOAD, 32'h00000000);
		bus(1'b1, dma_chan_pkg::OFS_STATUS, 32'h000000F4);
		rd(dma_chan_pkg::OFS_STATUS, 32'h00000008);
		bus(1'b1, dma_chan_pkg::OFS_STATUS, 32'h00000008);
		rd(dma_chan_pkg::OFS_STATUS, 32'h00000000);
		rd(8'h18, 32'h00000000);
		chk({31'h0, rerr}, 32'h00000001);
		// Four memory blocks cover every step code; the fifth is a hardware-driven flyby block
		for (int k = 0; k < 5; k++) begin
			n = 1 + $urandom % 6;
			rl = 1 + $urandom % 5;
			a0 = 24'($urandom);
			b0 = 24'($urandom);
			as = 24'($urandom);
			bs = 24'($urandom);
			ctl = 16'($urandom) & (k < 4 ? 16'h00AE : 16'h002E);
			ctl = ctl | 16'h1201 | 16'((k % 4) << 10) | 16'((k % 4) << 13);
			ctl = ctl | (k < 4 ? 16'h0110 : 16'h0000);
			gap <= k[0] ? 4'h3 : 4'h0;
			// Disable first: a count write to a live channel would start transfers early
			bus(1'b1, dma_chan_pkg::OFS_CONTROL, 32'h00000000);
			bus(1'b1, dma_chan_pkg::OFS_STATUS, 32'h0000000F);
			bus(1'b1, dma_chan_pkg::OFS_A_CURRENT, {8'h00, a0});
			bus(1'b1, dma_chan_pkg::OFS_B_CURRENT, {8'h00, b0});
			bus(1'b1, dma_chan_pkg::OFS_A_START, {8'h00, as});
			bus(1'b1, dma_chan_pkg::OFS_B_START, {8'h00, bs});
			bus(1'b1, dma_chan_pkg::OFS_COUNT_REMAIN, 32'(n));
			bus(1'b1, dma_chan_pkg::OFS_COUNT_RELOAD, 32'(rl));
			bus(1'b1, dma_chan_pkg::OFS_CONTROL, {16'h0000, ctl});
			HW_TRANSFER_REQUEST <= (k == 4);
			do bus(1'b0, dma_chan_pkg::OFS_STATUS, 32'h00000000); while (rdata[2] !== 1'b0);
			chk(rdata, 32'h00000003);
			HW_TRANSFER_REQUEST <= 1'b0;
			rd(dma_chan_pkg::OFS_A_CURRENT, {8'h00, 24'(as + rl * stp[k % 4])});
			rd(dma_chan_pkg::OFS_B_CURRENT, {8'h00, k < 4 ? 24'(bs + rl * stp[k % 4]) : b0});
			rd(dma_chan_pkg::OFS_COUNT_REMAIN, 32'h00000000);
			chk({31'h0, IRQ}, {31'h0, ctl[1] | ctl[2]});
		end
		bus(1'b1, dma_chan_pkg::OFS_COUNT_RELOAD, 32'h00000002);
		bus(1'b1, dma_chan_pkg::OFS_CONTROL, 32'h00000001);
		rd(dma_chan_pkg::OFS_STATUS, 32'h00000007);
		bus(1'b1, dma_chan_pkg::OFS_CONTROL, 32'h00000000);
		bus(1'b1, dma_chan_pkg::OFS_STATUS, 32'h0000000F);
		bus(1'b1, dma_chan_pkg::OFS_CONTROL, 32'h00000041);
		HW_TRANSFER_REQUEST <= 1'b1;
		do bus(1'b0, dma_chan_pkg::OFS_STATUS, 32'h00000000); while (rdata[1] !== 1'b1);
		chk(rdata, 32'h00000007);
		HW_TRANSFER_REQUEST <= 1'b0;
		bus(1'b1, dma_chan_pkg::OFS_CONTROL, 32'h00000000);
		chk({31'h0, DMA_CLK_EN}, 32'h00000000);
		conclude();
	end
endmodule // dma_channel_control_status_tb_top

/* File: tb/xfer_engine_model.sv */
/* Bus engine model: answers channel requests with one-cycle done pulses.
   Assumes the channel holds its request as a level. */
`timescale 1ns/10ps
module xfer_engine_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       xfer_req,
	input  wire logic       hold_bus,
	input  wire logic [3:0] gap,
	output logic            xfer_done
);
	logic [3:0] wait_cnt;
	// Intermittent mode gives the bus away for gap cycles; a slow bus is thus modelled too
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xfer_done <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (xfer_done) begin
			xfer_done <= 1'b0;
			wait_cnt <= hold_bus ? 4'h0 : gap;
		end else if (wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else begin
			xfer_done <= xfer_req;
		end
	end
endmodule // xfer_engine_model
